// *** hw/sac_pkg.sv ***
package sac_pkg;

  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_REF = 8'h04;
  localparam logic [7:0] OFF_CLK = 8'h08;
  localparam logic [7:0] OFF_RESH = 8'h0c;
  localparam logic [7:0] OFF_RESL = 8'h10;
  localparam logic [7:0] OFF_IRQ = 8'h14;

  localparam int ON_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHAN_LSB = 2;
  localparam int CHAN_W = 4;
  localparam int REFP_BIT = 4;
  localparam int REFN_BIT = 5;
  localparam int PINCFG_W = 4;
  localparam int JUST_BIT = 7;
  localparam int CSEL_W = 3;
  localparam int FLAG_BIT = 0;
  localparam int IEN_BIT = 1;
  localparam int RES_W = 10;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  localparam logic [2:0] CS_DIV2 = 3'h0;
  localparam logic [2:0] CS_DIV8 = 3'h1;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_DIV4 = 3'h4;
  localparam logic [2:0] CS_DIV16 = 3'h5;
  localparam logic [2:0] CS_DIV64 = 3'h6;
  localparam logic [1:0] CS_RC_LOW = 2'h3;

  localparam int DIV_W = 6;
  localparam int CONV_TAD = 12;
  localparam logic [1:0] RECOV_LAST = 2'h1;

  typedef enum logic [1:0] {SAC_IDLE, SAC_CONV, SAC_RECOV} sac_state_type;

  function automatic logic sac_is_rc(input logic [2:0] sel);
    return sel[1:0] == CS_RC_LOW;
  endfunction

  // Terminal count of the divider, period minus one
  function automatic logic [DIV_W-1:0] sac_div_last(input logic [2:0] sel);
    case (sel)
      CS_DIV2: return 6'h01;
      CS_DIV4: return 6'h03;
      CS_DIV8: return 6'h07;
      CS_DIV16: return 6'h0f;
      CS_DIV32: return 6'h1f;
      CS_DIV64: return 6'h3f;
      default: return 6'h00;
    endcase
  endfunction

endpackage

// *** hw/sac_tad_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
module sac_tad_gen
  import sac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] clock_sel,
  input wire logic rc_tick,
  input wire logic sleep_mode,
  output logic tad_tick
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic rc;
  logic halt;

  always_comb
  begin
    rc = sac_is_rc(clock_sel);
    halt = sleep_mode && !rc;
    tad_tick = run && !halt &&
      (rc ? rc_tick : cnt == sac_div_last(clock_sel));
    next_cnt = cnt + 6'h01;
    if (!run || rc || halt || cnt == sac_div_last(clock_sel))
    begin
      next_cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= '0;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end

  property p_rc_source;
    @(posedge pclk) disable iff (!presetn)
    run && sac_is_rc(clock_sel) |-> tad_tick == rc_tick;
  endproperty
  a_rc_source: assert property (p_rc_source)
    else $error("rc tick mismatch");

  property p_div2;
    @(posedge pclk) disable iff (!presetn)
    tad_tick && run && !sleep_mode && clock_sel == CS_DIV2 ##1
    run && !sleep_mode && clock_sel == CS_DIV2 |-> !tad_tick ##1 tad_tick;
  endproperty
  a_div2: assert property (p_div2)
    else $error("div2 period wrong");

  property p_sleep_stall;
    @(posedge pclk) disable iff (!presetn)
    sleep_mode && !sac_is_rc(clock_sel) |-> !tad_tick;
  endproperty
  a_sleep_stall: assert property (p_sleep_stall)
    else $error("tick in sleep");

endmodule
`default_nettype wire

// *** hw/sac_sar.sv ***
`timescale 1ns/10ps
`default_nettype none
module sac_sar #(
  parameter int WIDTH = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic abort,
  input wire logic tad_tick,
  input wire logic cmp_in,
  output logic [WIDTH-1:0] code,
  output logic done
);

  localparam int STEP_W = $clog2(WIDTH + 2);
  localparam logic [STEP_W-1:0] LAST = STEP_W'(WIDTH + 1);

  if (WIDTH < 2 || WIDTH > 16)
  begin : g_bad_width
    $error("sac_sar: WIDTH out of range");
  end

  logic active;
  logic next_active;
  logic [STEP_W-1:0] step;
  logic [STEP_W-1:0] next_step;
  logic [WIDTH-1:0] next_code;

  // Step 0 is the disconnect period, one bit per step for steps 1 to WIDTH, done at step LAST
  always_comb
  begin
    next_code = code;
    next_step = step;
    next_active = active;
    done = active && tad_tick && step == LAST;
    if (start)
    begin
      next_active = 1'b1;
      next_step = '0;
      next_code = '0;
      next_code[WIDTH-1] = 1'b1;
    end
    else if (abort)
    begin
      next_active = 1'b0;
    end
    else if (active && tad_tick)
    begin
      next_step = step + 1'b1;
      if (step == LAST)
      begin
        next_active = 1'b0;
      end
      for (int i = 0; i < WIDTH; i++)
      begin
        if (step == STEP_W'(WIDTH - i))
        begin
          next_code[i] = cmp_in;
        end
      end
      for (int i = 1; i < WIDTH; i++)
      begin
        if (step == STEP_W'(WIDTH - i))
        begin
          next_code[i-1] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active <= 1'b0;
      step <= '0;
      code <= '0;
    end
    else
    begin
      active <= next_active;
      step <= next_step;
      code <= next_code;
    end
  end

  property p_one_bit_per_tick;
    @(posedge pclk) disable iff (!presetn)
    !tad_tick && !start |=> $stable(code);
  endproperty
  a_one_bit_per_tick: assert property (p_one_bit_per_tick)
    else $error("code moved without tick");

  property p_done_at_last;
    @(posedge pclk) disable iff (!presetn)
    done |-> step == LAST && active;
  endproperty
  a_done_at_last: assert property (p_done_at_last)
    else $error("done at wrong step");

endmodule
`default_nettype wire

// *** hw/sac_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module sac_top
  import sac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_tick,
  input wire logic sleep_mode,
  input wire logic cmp_in,
  output logic [RES_W-1:0] dac_code,
  output logic hold_connect,
  output logic converter_enable,
  output logic conv_busy,
  output logic [CHAN_W-1:0] input_channel_sel,
  output logic ref_pos_ext,
  output logic ref_neg_ext,
  output logic [PINCFG_W-1:0] pin_cfg,
  output logic conv_done_irq_flag,
  output logic conv_done_irq_enable
);

  logic [7:0] conv_main_ctrl, next_conv_main_ctrl;
  logic [7:0] ref_and_pin_cfg, next_ref_and_pin_cfg;
  logic result_justify_sel, next_result_justify_sel;
  logic [CSEL_W-1:0] conv_clock_sel, next_conv_clock_sel;
  logic [7:0] result_high_byte, next_result_high_byte;
  logic [7:0] result_low_byte, next_result_low_byte;
  logic flag, next_flag;
  logic irq_en, next_irq_en;
  logic [31:0] next_prdata;
  sac_state_type state, next_state;
  logic [1:0] rec_cnt, next_rec_cnt;
  logic converter_on, go, wr, wr_main, wr_res, mapped;
  logic tad_tick, sar_start, sar_abort, sar_done;
  logic [RES_W-1:0] sar_code;
  logic [15:0] packed_res;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == OFF_MAIN || a == OFF_REF || a == OFF_CLK ||
      a == OFF_RESH || a == OFF_RESL || a == OFF_IRQ;
  endfunction

  // Unused positions stay zero in both formats
  function automatic logic [15:0] justify(input logic [RES_W-1:0] r,
    input logic right);
    return right ? {6'h00, r} : {r, 6'h00};
  endfunction

  assign converter_on = conv_main_ctrl[ON_BIT];
  assign go = conv_main_ctrl[GO_BIT];
  assign wr = psel && penable && pwrite;
  assign wr_main = wr && paddr == OFF_MAIN;
  assign wr_res = wr && (paddr == OFF_RESH || paddr == OFF_RESL);
  assign mapped = is_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign converter_enable = converter_on;
  assign conv_busy = go;
  assign input_channel_sel = conv_main_ctrl[CHAN_LSB +: CHAN_W];
  assign ref_pos_ext = ref_and_pin_cfg[REFP_BIT];
  assign ref_neg_ext = ref_and_pin_cfg[REFN_BIT];
  assign pin_cfg = ref_and_pin_cfg[PINCFG_W-1:0];
  assign conv_done_irq_flag = flag;
  assign conv_done_irq_enable = irq_en;
  assign dac_code = sar_code;
  assign hold_connect = converter_on && state == SAC_IDLE;
  assign packed_res = justify(sar_code, result_justify_sel);

  // Aborting on a registered go costs one cycle, at most half of one period
  assign sar_abort = state == SAC_CONV && !sar_done &&
    (!go || !converter_on);

  sac_tad_gen u_tad (
    .pclk(pclk),
    .presetn(presetn),
    .run(state != SAC_IDLE),
    .clock_sel(conv_clock_sel),
    .rc_tick(rc_tick),
    .sleep_mode(sleep_mode),
    .tad_tick(tad_tick)
  );

  sac_sar #(
    .WIDTH(RES_W)
  ) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .start(sar_start),
    .abort(sar_abort),
    .tad_tick(tad_tick),
    .cmp_in(cmp_in),
    .code(sar_code),
    .done(sar_done)
  );

  always_comb
  begin
    next_state = state;
    next_rec_cnt = rec_cnt;
    sar_start = 1'b0;
    case (state)
      SAC_IDLE:
      begin
        if (go && converter_on)
        begin
          sar_start = 1'b1;
          next_state = SAC_CONV;
        end
      end
      SAC_CONV:
      begin
        if (sar_done || sar_abort)
        begin
          next_state = SAC_RECOV;
          next_rec_cnt = '0;
        end
      end
      SAC_RECOV:
      begin
        if (!converter_on)
          next_state = SAC_IDLE;
        else if (tad_tick)
        begin
          next_rec_cnt = rec_cnt + 2'h1;
          if (rec_cnt == RECOV_LAST)
          begin
            next_state = SAC_IDLE;
          end
        end
      end
      default: next_state = SAC_IDLE;
    endcase
  end

  always_comb
  begin
    next_conv_main_ctrl = conv_main_ctrl;
    next_ref_and_pin_cfg = ref_and_pin_cfg;
    next_result_justify_sel = result_justify_sel;
    next_conv_clock_sel = conv_clock_sel;
    next_result_high_byte = result_high_byte;
    next_result_low_byte = result_low_byte;
    next_flag = flag;
    next_irq_en = irq_en;
    if (sar_done)
    begin
      next_result_high_byte = packed_res[15:8];
      next_result_low_byte = packed_res[7:0];
      next_conv_main_ctrl[GO_BIT] = 1'b0;
    end
    if (wr)
    begin
      case (paddr)
        OFF_MAIN:
        begin
          next_conv_main_ctrl[ON_BIT] = pwdata[ON_BIT];
          next_conv_main_ctrl[CHAN_LSB +: CHAN_W] =
            pwdata[CHAN_LSB +: CHAN_W];
          // Start needs the converter already on; a set beats the clear
          next_conv_main_ctrl[GO_BIT] = pwdata[GO_BIT] && converter_on &&
            pwdata[ON_BIT];
        end
        OFF_REF: next_ref_and_pin_cfg = {2'h0, pwdata[5:0]};
        OFF_CLK:
        begin
          next_result_justify_sel = pwdata[JUST_BIT];
          next_conv_clock_sel = pwdata[CSEL_W-1:0];
        end
        OFF_RESH: next_result_high_byte = pwdata[7:0];
        OFF_RESL: next_result_low_byte = pwdata[7:0];
        OFF_IRQ:
        begin
          next_flag = pwdata[FLAG_BIT];
          next_irq_en = pwdata[IEN_BIT];
        end
        default:
        begin
        end
      endcase
    end
    if (sar_done)
    begin
      next_flag = 1'b1;
    end
    if (!next_conv_main_ctrl[ON_BIT])
    begin
      next_conv_main_ctrl[GO_BIT] = 1'b0;
    end
  end

  always_comb
  begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite)
    begin
      next_prdata = RST_WORD;
      case (paddr)
        OFF_MAIN: next_prdata[7:0] = conv_main_ctrl;
        OFF_REF: next_prdata[7:0] = ref_and_pin_cfg;
        OFF_CLK: next_prdata[7:0] = {result_justify_sel, 4'h0,
          conv_clock_sel};
        OFF_RESH: next_prdata[7:0] = result_high_byte;
        OFF_RESL: next_prdata[7:0] = result_low_byte;
        OFF_IRQ: next_prdata[7:0] = {6'h00, irq_en, flag};
        default: next_prdata = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= SAC_IDLE;
      rec_cnt <= '0;
      conv_main_ctrl <= RST_BYTE;
      ref_and_pin_cfg <= RST_BYTE;
      result_justify_sel <= 1'b0;
      conv_clock_sel <= '0;
      flag <= 1'b0;
      irq_en <= 1'b0;
      prdata <= RST_WORD;
    end
    else
    begin
      state <= next_state;
      rec_cnt <= next_rec_cnt;
      conv_main_ctrl <= next_conv_main_ctrl;
      ref_and_pin_cfg <= next_ref_and_pin_cfg;
      result_justify_sel <= next_result_justify_sel;
      conv_clock_sel <= next_conv_clock_sel;
      flag <= next_flag;
      irq_en <= next_irq_en;
      prdata <= next_prdata;
    end
  end

  // No reset on purpose: result survives any reset
  always_ff @(posedge pclk)
  begin
    result_high_byte <= next_result_high_byte;
    result_low_byte <= next_result_low_byte;
  end

  property p_done_effects;
    @(posedge pclk) disable iff (!presetn)
    sar_done |=> flag && (!go || $past(wr_main)) && state == SAC_RECOV;
  endproperty
  a_done_effects: assert property (p_done_effects)
    else $error("done effects missing");
  property p_abort_keeps;
    @(posedge pclk) disable iff (!presetn)
    sar_abort && !wr_res |=> $stable(result_high_byte) &&
      $stable(result_low_byte) && state == SAC_RECOV;
  endproperty
  a_abort_keeps: assert property (p_abort_keeps)
    else $error("abort changed result");
  property p_hold_off;
    @(posedge pclk) disable iff (!presetn)
    state != SAC_IDLE |-> !hold_connect;
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("hold connected in conversion");
  property p_recov_two;
    @(posedge pclk) disable iff (!presetn)
    $past(state) == SAC_RECOV && state == SAC_IDLE && converter_on |->
      $past(rec_cnt) == RECOV_LAST && $past(tad_tick);
  endproperty
  a_recov_two: assert property (p_recov_two)
    else $error("recovery too short");
  property p_clk_unimpl;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == OFF_CLK |=> prdata[6:3] == 4'h0;
  endproperty
  a_clk_unimpl: assert property (p_clk_unimpl)
    else $error("unimplemented bits set");
  property p_right_zero;
    @(posedge pclk) disable iff (!presetn)
    sar_done && result_justify_sel && !wr_res |=>
      result_high_byte[7:2] == 6'h00;
  endproperty
  a_right_zero: assert property (p_right_zero)
    else $error("right format upper bits");
  property p_start_needs_on;
    @(posedge pclk) disable iff (!presetn)
    sar_start |-> converter_on ##1 state == SAC_CONV;
  endproperty
  a_start_needs_on: assert property (p_start_needs_on)
    else $error("start while off");
  property p_off_stops;
    @(posedge pclk) disable iff (!presetn)
    !converter_on |-> !go ##1 state != SAC_CONV;
  endproperty
  a_off_stops: assert property (p_off_stops)
    else $error("off did not stop");
  c_done: cover property (@(posedge pclk) disable iff (!presetn) sar_done);
  c_abort: cover property (@(posedge pclk) disable iff (!presetn) sar_abort);
  c_sleep_done: cover property (@(posedge pclk) disable iff (!presetn)
    sar_done && sleep_mode);

endmodule
`default_nettype wire

// *** test/sac_analog_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sac_analog_model #(
  parameter int RC_P = 100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [9:0] dac_code,
  input wire logic [9:0] vin,
  output logic cmp_in,
  output logic rc_tick
);
  int cnt;
  // Ideal comparator: no offset, so a search lands exactly on vin
  assign cmp_in = (vin >= dac_code);
  // Free running RC source, 100 cycles is 1 MHz at 100 MHz
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      rc_tick <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == RC_P - 1) ? 0 : cnt + 1;
      rc_tick <= (cnt == RC_P - 1);
    end
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb
  import sac_pkg::*;
;
  localparam int RC_P = 100;
  localparam int ACQ = 20;
  logic pclk, presetn, psel, penable, pwrite, sleep_mode;
  logic [7:0] paddr, m_hi, m_lo;
  logic [31:0] pwdata, prdata, rd, r;
  logic pready, pslverr, rc_tick, cmp_in, hold_connect, converter_enable;
  logic conv_busy, ref_pos_ext, ref_neg_ext, conv_done_irq_flag;
  logic conv_done_irq_enable, last_err;
  logic [RES_W-1:0] dac_code, vin;
  logic [CHAN_W-1:0] input_channel_sel;
  logic [PINCFG_W-1:0] pin_cfg;
  int err_count, n_checks, t;
  int per [8] = '{2, 8, 32, RC_P, 4, 16, 64, RC_P};

  sac_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_tick(rc_tick),
    .sleep_mode(sleep_mode), .cmp_in(cmp_in), .dac_code(dac_code),
    .hold_connect(hold_connect), .converter_enable(converter_enable),
    .conv_busy(conv_busy), .input_channel_sel(input_channel_sel),
    .ref_pos_ext(ref_pos_ext), .ref_neg_ext(ref_neg_ext), .pin_cfg(pin_cfg),
    .conv_done_irq_flag(conv_done_irq_flag),
    .conv_done_irq_enable(conv_done_irq_enable));
  sac_analog_model #(.RC_P(RC_P)) model (.pclk(pclk), .presetn(presetn),
    .dac_code(dac_code), .vin(vin), .cmp_in(cmp_in), .rc_tick(rc_tick));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_idle();
    t = 0;
    while (conv_busy !== 1'b0 && t < 5000)
    begin
      @(posedge pclk);
      t++;
    end
  endtask

  task automatic conv(input logic [2:0] code, input logic right,
    input logic slp);
    logic [9:0] v;
    logic [3:0] ch;
    logic in_time;
    v = 10'($urandom);
    ch = 4'($urandom);
    vin <= v;
    sleep_mode <= slp;
    apb(1'b1, OFF_CLK, {24'h0, right, 4'h0, code});
    apb(1'b1, OFF_MAIN, {26'h0, ch, 2'h1});
    repeat (ACQ) @(posedge pclk);
    apb(1'b1, OFF_MAIN, {26'h0, ch, 2'h3});
    @(posedge pclk);
    #1;
    chk({31'h0, hold_connect}, 32'h0);
    // Divided clocks freeze in sleep, so the conversion must wait
    if (slp && code[1:0] != 2'h3)
    begin
      repeat (200) @(posedge pclk);
      chk({31'h0, conv_busy}, 32'h1);
      sleep_mode <= 1'b0;
    end
    wait_idle();
    chk({31'h0, t < 5000}, 32'h1);
    in_time = t >= 11 * per[code] && t <= 13 * per[code] + 8;
    if (!slp)
      chk({31'h0, in_time}, 32'h1);
    chk({22'h0, dac_code}, {22'h0, v});
    chk({30'h0, conv_done_irq_enable, conv_done_irq_flag}, 32'h3);
    chk({28'h0, input_channel_sel}, {28'h0, ch});
    #1;
    chk({31'h0, hold_connect}, 32'h0);
    m_hi = right ? {6'h0, v[9:8]} : v[9:2];
    m_lo = right ? v[7:0] : {v[1:0], 6'h0};
    rchk(OFF_RESH, {24'h0, m_hi});
    rchk(OFF_RESL, {24'h0, m_lo});
    rchk(OFF_MAIN, {26'h0, ch, 2'h1});
    rchk(OFF_IRQ, 32'h3);
    apb(1'b1, OFF_IRQ, 32'h2);
    rchk(OFF_IRQ, 32'h2);
    repeat (2 * per[code] + 4) @(posedge pclk);
    chk({31'h0, hold_connect}, 32'h1);
    sleep_mode <= 1'b0;
    $display("test conversion code %0d sleep %0d done", code, slp);
  endtask

  initial
  begin
    repeat (60000) @(posedge pclk);
    err_count++;
    conclude();
  end

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_mode = 1'b0;
    vin = 10'h000;
    presetn = 1'b0;
    err_count = 0;
    n_checks = 0;
    void'($urandom(32'h216606cf));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFF_MAIN, 32'h0);
    rchk(OFF_REF, 32'h0);
    rchk(OFF_CLK, 32'h0);
    rchk(OFF_IRQ, 32'h0);
    rchk(8'h18, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    apb(1'b1, OFF_CLK, 32'hff);
    rchk(OFF_CLK, 32'h87);
    r = $urandom & 32'h3f;
    apb(1'b1, OFF_REF, r);
    rchk(OFF_REF, r);
    chk({26'h0, ref_neg_ext, ref_pos_ext, pin_cfg}, r);
    apb(1'b1, OFF_MAIN, 32'h3);
    repeat (3) @(posedge pclk);
    chk({30'h0, conv_busy, converter_enable}, 32'h1);
    $display("test registers done");
    apb(1'b1, OFF_IRQ, 32'h2);
    for (int c = 0; c < 8; c++)
      conv(3'(c), 1'($urandom), 1'b0);
    conv(3'h7, 1'b1, 1'b1);
    conv(3'h1, 1'b0, 1'b1);
    apb(1'b1, OFF_CLK, 32'h80);
    vin <= ~vin;
    repeat (ACQ) @(posedge pclk);
    apb(1'b1, OFF_MAIN, 32'h7);
    repeat (6) @(posedge pclk);
    apb(1'b1, OFF_MAIN, 32'h5);
    repeat (40) @(posedge pclk);
    chk({31'h0, conv_busy}, 32'h0);
    rchk(OFF_RESH, {24'h0, m_hi});
    rchk(OFF_RESL, {24'h0, m_lo});
    rchk(OFF_IRQ, 32'h2);
    $display("test abort done");
    apb(1'b1, OFF_CLK, 32'h82);
    apb(1'b1, OFF_MAIN, 32'h7);
    repeat (50) @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFF_MAIN, 32'h0);
    rchk(OFF_CLK, 32'h0);
    chk({30'h0, converter_enable, hold_connect}, 32'h0);
    chk({30'h0, conv_done_irq_enable, conv_done_irq_flag}, 32'h0);
    rchk(OFF_RESH, {24'h0, m_hi});
    rchk(OFF_RESL, {24'h0, m_lo});
    $display("test reset mid conversion done");
    conclude();
  end
endmodule
`default_nettype wire
